// *** ipr_level_map.sv ***
/*
 * Turns a stored priority code into the level and request-allowed flag
 * seen by the arbitration logic. Purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module ipr_level_map
	import ipr_pkg::*;
(
	input wire logic [IPR_CODE_W-1:0] code,
	output logic [IPR_CODE_W-1:0] level,
	output logic active
);

	// Linear map: code 1 is level 1, all-ones is level 7
	assign level = code; // R1 R3
	// Zero code blocks the source whatever its flag and enable say
	assign active = (code != IPR_CODE_OFF); // R2

endmodule : ipr_level_map

`default_nettype wire

// *** ipr_pkg.sv ***
/*
 * Shared constants for the interrupt priority register bank: register
 * indices on the plain register port, field positions and reset codes.
 * Assumes a 16-bit data path and 3-bit priority fields.
 */
`default_nettype none

package ipr_pkg;

	localparam int IPR_NUM_SRC = 16;
	localparam int IPR_ADDR_W = 3;
	localparam int IPR_DATA_W = 16;
	localparam int IPR_CODE_W = 3;

	typedef logic [IPR_CODE_W-1:0] ipr_code_t;
	typedef logic [IPR_ADDR_W-1:0] ipr_addr_t;
	typedef logic [IPR_DATA_W-1:0] ipr_data_t;

	// Register indices on the register port
	localparam ipr_addr_t IPR_ADDR_CRC_UART = 3'h0;
	localparam ipr_addr_t IPR_ADDR_LOW_VOLT = 3'h1;
	localparam ipr_addr_t IPR_ADDR_CHARGE = 3'h2;
	localparam ipr_addr_t IPR_ADDR_SERIAL3 = 3'h3;
	localparam ipr_addr_t IPR_ADDR_USB_I2C3 = 3'h4;
	localparam ipr_addr_t IPR_ADDR_SPI3_SER4 = 3'h5;
	localparam ipr_addr_t IPR_ADDR_OFF_MAP = 3'h6;

	// Field low-bit positions
	localparam int IPR_LSB_14 = 12;
	localparam int IPR_LSB_10 = 8;
	localparam int IPR_LSB_6 = 4;
	localparam int IPR_LSB_2 = 0;

	// Field codes
	localparam ipr_code_t IPR_CODE_RESET = 3'h4;
	localparam ipr_code_t IPR_CODE_OFF = 3'h0;

	// Source index order:
	// 0 crc err, 1 ser2 err, 2 ser1 err, 3 low volt, 4 charge time,
	// 5 ser3 tx, 6 ser3 rx, 7 ser3 err, 8 ser4 err, 9 usb otg,
	// 10 i2c3 master, 11 i2c3 slave, 12 spi3 event, 13 spi3 fault,
	// 14 ser4 tx, 15 ser4 rx
	localparam ipr_addr_t IPR_SRC_REG [IPR_NUM_SRC] = '{
		3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3,
		3'h4, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5};
	localparam int IPR_SRC_LSB [IPR_NUM_SRC] = '{
		12, 8, 4, 0, 4, 12, 8, 4,
		12, 8, 4, 0, 12, 8, 4, 0};

endpackage : ipr_pkg

`default_nettype wire

// *** ipr_prio_bank.sv ***
/*
 * Interrupt priority register bank, upper range: six 16-bit registers of
 * 3-bit priority fields plus a read-only map of disabled sources.
 * Assumes a plain register port on the same clock: one-cycle write and
 * read strobes, never together, read data in the cycle after the strobe.
 */
// Notes on behaviour
// R1: Field code all-ones means priority level 7, the highest.
// R2: Code zero disables the source; it never requests service.
// R3: Code one is level 1; codes between map linearly up to 7.
// R4: Unimplemented bits, including the bit above each field, read zero.
// R5: Power-on reset loads each field with binary 100.
// R6: Field bits are read/write; reads give last write or reset value.
// R7: First register: crc error 14-12, serial two 10-8, serial one 6-4.
// R8: Low-voltage register: field in 2-0, bits 15-3 unimplemented.
// R9: Charge-time register: field in 6-4, bits 15-7 and 3-0 unimplemented.
// R10: Serial three register: transmit 14-12, receive 10-8, error 6-4.
// R11: Serial four error 14-12, usb 10-8, i2c master 6-4, slave 2-0.
// R12: Spi event 14-12, spi fault 10-8, serial four tx 6-4, rx 2-0.
// R13: After reset every covered source sits at priority level 4.
// R14: Writes to unimplemented bits are ignored and disturb no field.
`timescale 1ns/1ps
`default_nettype none

module ipr_prio_bank
	import ipr_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [IPR_ADDR_W-1:0] bus_addr,
	input wire logic [IPR_DATA_W-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [IPR_DATA_W-1:0] bus_rdata,
	output logic [IPR_CODE_W-1:0] crc_error_level,
	output logic crc_error_active,
	output logic [IPR_CODE_W-1:0] serial_two_error_level,
	output logic serial_two_error_active,
	output logic [IPR_CODE_W-1:0] serial_one_error_level,
	output logic serial_one_error_active,
	output logic [IPR_CODE_W-1:0] low_voltage_level,
	output logic low_voltage_active,
	output logic [IPR_CODE_W-1:0] charge_time_level,
	output logic charge_time_active,
	output logic [IPR_CODE_W-1:0] serial_three_tx_level,
	output logic serial_three_tx_active,
	output logic [IPR_CODE_W-1:0] serial_three_rx_level,
	output logic serial_three_rx_active,
	output logic [IPR_CODE_W-1:0] serial_three_error_level,
	output logic serial_three_error_active,
	output logic [IPR_CODE_W-1:0] serial_four_error_level,
	output logic serial_four_error_active,
	output logic [IPR_CODE_W-1:0] usb_otg_level,
	output logic usb_otg_active,
	output logic [IPR_CODE_W-1:0] i2c_three_master_level,
	output logic i2c_three_master_active,
	output logic [IPR_CODE_W-1:0] i2c_three_slave_level,
	output logic i2c_three_slave_active,
	output logic [IPR_CODE_W-1:0] spi_three_event_level,
	output logic spi_three_event_active,
	output logic [IPR_CODE_W-1:0] spi_three_fault_level,
	output logic spi_three_fault_active,
	output logic [IPR_CODE_W-1:0] serial_four_tx_level,
	output logic serial_four_tx_active,
	output logic [IPR_CODE_W-1:0] serial_four_rx_level,
	output logic serial_four_rx_active
);

	typedef struct packed {
		logic [IPR_DATA_W-1:0] rdata;
	} ipr_bank_s;

	ipr_bank_s st_r;
	ipr_bank_s st_nxt;

	ipr_code_t code_w [IPR_NUM_SRC];
	ipr_code_t level_w [IPR_NUM_SRC];
	logic [IPR_NUM_SRC-1:0] active_w;
	logic [IPR_NUM_SRC-1:0] wr_hit_w;

	logic [IPR_DATA_W-1:0] img_crc_uart;
	logic [IPR_DATA_W-1:0] img_low_volt;
	logic [IPR_DATA_W-1:0] img_charge;
	logic [IPR_DATA_W-1:0] img_serial3;
	logic [IPR_DATA_W-1:0] img_usb_i2c3;
	logic [IPR_DATA_W-1:0] img_spi3_ser4;
	logic [IPR_DATA_W-1:0] img_off_map;

	// One field store and one level map per source
	for (genvar g = 0; g < IPR_NUM_SRC; g++)
	begin : g_src
		// Only the three field bits reach the store, so writes to the
		// unimplemented bits around it have nowhere to land
		assign wr_hit_w[g] = bus_wr && (bus_addr == IPR_SRC_REG[g]); // R14

		ipr_prio_field #(
			.CODE_W(IPR_CODE_W)
		) u_field (
			.clock(clock),
			.rst(rst),
			.wr_en(wr_hit_w[g]),
			.wr_code(bus_wdata[IPR_SRC_LSB[g] +: IPR_CODE_W]), // R6 R14
			.code(code_w[g])
		);

		ipr_level_map u_map (
			.code(code_w[g]),
			.level(level_w[g]),
			.active(active_w[g])
		);
	end

	// Read images; every bit not named here is a constant zero
	assign img_crc_uart = {
		1'b0, code_w[0],
		1'b0, code_w[1],
		1'b0, code_w[2],
		4'h0
	}; // R4 R7

	assign img_low_volt = {
		13'h0000,
		code_w[3]
	}; // R4 R8

	assign img_charge = {
		9'h000,
		code_w[4],
		4'h0
	}; // R4 R9

	assign img_serial3 = {
		1'b0, code_w[5],
		1'b0, code_w[6],
		1'b0, code_w[7],
		4'h0
	}; // R4 R10

	assign img_usb_i2c3 = {
		1'b0, code_w[8],
		1'b0, code_w[9],
		1'b0, code_w[10],
		1'b0, code_w[11]
	}; // R4 R11

	assign img_spi3_ser4 = {
		1'b0, code_w[12],
		1'b0, code_w[13],
		1'b0, code_w[14],
		1'b0, code_w[15]
	}; // R4 R12

	// Lets software confirm which sources are blocked without decoding
	// every field; one bit per source in source index order
	assign img_off_map = ~active_w; // R2

	// Read data stand only in the cycle after the strobe, zero otherwise,
	// so a stale value can never be mistaken for a fresh answer
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rdata = '0;
		if (bus_rd)
		begin
			if (bus_addr == IPR_ADDR_CRC_UART)
			begin
				st_nxt.rdata = img_crc_uart; // R6
			end
			else if (bus_addr == IPR_ADDR_LOW_VOLT)
			begin
				st_nxt.rdata = img_low_volt;
			end
			else if (bus_addr == IPR_ADDR_CHARGE)
			begin
				st_nxt.rdata = img_charge;
			end
			else if (bus_addr == IPR_ADDR_SERIAL3)
			begin
				st_nxt.rdata = img_serial3;
			end
			else if (bus_addr == IPR_ADDR_USB_I2C3)
			begin
				st_nxt.rdata = img_usb_i2c3;
			end
			else if (bus_addr == IPR_ADDR_SPI3_SER4)
			begin
				st_nxt.rdata = img_spi3_ser4;
			end
			else if (bus_addr == IPR_ADDR_OFF_MAP)
			begin
				st_nxt.rdata = img_off_map;
			end
			else
			begin
				st_nxt.rdata = '0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			st_r.rdata <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign bus_rdata = st_r.rdata;

	// Field stores reset to code 100, so every source starts at level 4
	assign crc_error_level = level_w[0]; // R13
	assign crc_error_active = active_w[0];
	assign serial_two_error_level = level_w[1];
	assign serial_two_error_active = active_w[1];
	assign serial_one_error_level = level_w[2];
	assign serial_one_error_active = active_w[2];
	assign low_voltage_level = level_w[3];
	assign low_voltage_active = active_w[3];
	assign charge_time_level = level_w[4];
	assign charge_time_active = active_w[4];
	assign serial_three_tx_level = level_w[5];
	assign serial_three_tx_active = active_w[5];
	assign serial_three_rx_level = level_w[6];
	assign serial_three_rx_active = active_w[6];
	assign serial_three_error_level = level_w[7];
	assign serial_three_error_active = active_w[7];
	assign serial_four_error_level = level_w[8];
	assign serial_four_error_active = active_w[8];
	assign usb_otg_level = level_w[9];
	assign usb_otg_active = active_w[9];
	assign i2c_three_master_level = level_w[10];
	assign i2c_three_master_active = active_w[10];
	assign i2c_three_slave_level = level_w[11];
	assign i2c_three_slave_active = active_w[11];
	assign spi_three_event_level = level_w[12];
	assign spi_three_event_active = active_w[12];
	assign spi_three_fault_level = level_w[13];
	assign spi_three_fault_active = active_w[13];
	assign serial_four_tx_level = level_w[14];
	assign serial_four_tx_active = active_w[14];
	assign serial_four_rx_level = level_w[15];
	assign serial_four_rx_active = active_w[15];

endmodule : ipr_prio_bank

`default_nettype wire

// *** ipr_prio_bank_chk.sv ***
/*
 * Port-level assertions for the priority register bank.
 * Assumes the bench keeps strobes one cycle long and never together.
 */
`timescale 1ns/1ps
`default_nettype none
module ipr_prio_bank_chk
	import ipr_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [IPR_ADDR_W-1:0] bus_addr,
	input wire logic [IPR_DATA_W-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [IPR_DATA_W-1:0] bus_rdata,
	input wire logic [IPR_CODE_W-1:0] crc_error_level,
	input wire logic crc_error_active,
	input wire logic [IPR_CODE_W-1:0] serial_one_error_level,
	input wire logic [IPR_CODE_W-1:0] serial_four_error_level,
	input wire logic [IPR_CODE_W-1:0] usb_otg_level,
	input wire logic [IPR_CODE_W-1:0] i2c_three_master_level,
	input wire logic [IPR_CODE_W-1:0] i2c_three_slave_level,
	input wire logic [IPR_CODE_W-1:0] serial_four_rx_level
);
	logic [IPR_DATA_W-1:0] wd_r;
	// Keeps write data one cycle so field updates can be compared after the edge
	always_ff @(posedge clock)
	begin
		wd_r <= bus_wdata;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_rd_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
		else $error("read data not zero outside answer cycle");
	a_rd_gap_bits: assert property ($past(bus_rd) && $past(bus_addr) != 3'h6 |-> (bus_rdata & 16'h8888) == 16'h0000)
		else $error("bit above a field read as one");
	a_low_volt_bits: assert property ($past(bus_rd) && $past(bus_addr) == 3'h1 |-> bus_rdata[15:3] == 13'h0000)
		else $error("low voltage register upper bits not zero");
	a_charge_bits: assert property ($past(bus_rd) && $past(bus_addr) == 3'h2 |-> (bus_rdata & 16'hFF8F) == 16'h0000)
		else $error("charge time register spare bits not zero");
	a_usb_read_back: assert property ($past(bus_rd) && $past(bus_addr) == 3'h4 |->
		bus_rdata == {1'b0, serial_four_error_level, 1'b0, usb_otg_level, 1'b0, i2c_three_master_level, 1'b0,
		i2c_three_slave_level})
		else $error("usb register read differs from fields");
	a_crc_write: assert property (bus_wr && bus_addr == 3'h0 |=> crc_error_level == wd_r[14:12]
		&& serial_one_error_level == wd_r[6:4])
		else $error("first register fields not loaded");
	a_rx_write: assert property (bus_wr && bus_addr == 3'h5 |=> serial_four_rx_level == wd_r[2:0])
		else $error("serial four rx field not loaded");
	a_level_hold: assert property (!(bus_wr && bus_addr == 3'h4) |=> $stable(usb_otg_level))
		else $error("usb level changed without its write");
	a_active_code: assert property (crc_error_active == (crc_error_level != 3'h0))
		else $error("active flag does not follow code");
	a_reset_code: assert property ($past(rst) |-> serial_four_rx_level == 3'h4 && usb_otg_level == 3'h4)
		else $error("field not at level four after reset");
	c_write_off: cover property (bus_wr && bus_wdata[14:12] == 3'h0);
	c_read_map: cover property (bus_rd && bus_addr == 3'h6);
	c_reset_mid: cover property ($fell(rst));
endmodule : ipr_prio_bank_chk
bind ipr_prio_bank ipr_prio_bank_chk ipr_prio_bank_chk_inst (.clock(clock), .rst(rst), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.crc_error_level(crc_error_level), .crc_error_active(crc_error_active),
	.serial_one_error_level(serial_one_error_level), .serial_four_error_level(serial_four_error_level),
	.usb_otg_level(usb_otg_level), .i2c_three_master_level(i2c_three_master_level),
	.i2c_three_slave_level(i2c_three_slave_level), .serial_four_rx_level(serial_four_rx_level));
`default_nettype wire

// *** ipr_prio_field.sv ***
/*
 * One software-writable priority field with its power-on code.
 * Assumes the write enable is already decoded for this field alone.
 */
`timescale 1ns/1ps
`default_nettype none

module ipr_prio_field
	import ipr_pkg::*;
#(
	parameter int CODE_W = IPR_CODE_W
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [CODE_W-1:0] wr_code,
	output logic [CODE_W-1:0] code
);

	if (CODE_W != IPR_CODE_W)
	begin : g_bad_width
		$error("ipr_prio_field: field width must be 3");
	end

	typedef struct packed {
		logic [CODE_W-1:0] code;
	} ipr_field_s;

	ipr_field_s st_r;
	ipr_field_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (wr_en)
		begin
			st_nxt.code = wr_code; // R6
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			st_r.code <= IPR_CODE_RESET; // R5
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign code = st_r.code;

endmodule : ipr_prio_field

`default_nettype wire

// *** tb_top.sv ***
/*
 * Self-checking bench for the priority register bank.
 * Assumes the bench alone drives the register port; a shadow model predicts reads.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import ipr_pkg::*;
();
	localparam logic [15:0] MSK [6] = '{16'h7770, 16'h0007, 16'h0070, 16'h7770, 16'h7777, 16'h7777};
	logic clock, rst, bus_wr, bus_rd;
	ipr_addr_t bus_addr;
	ipr_data_t bus_wdata, bus_rdata;
	logic [2:0] lv [16];
	logic ac [16];
	logic [15:0] mdl [6];
	int err_count, samples_checked, cyc;
	integer seed = 32'hF505C144;
	ipr_prio_bank ipr_prio_bank_inst (.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.crc_error_level(lv[0]), .crc_error_active(ac[0]), .serial_two_error_level(lv[1]),
		.serial_two_error_active(ac[1]), .serial_one_error_level(lv[2]), .serial_one_error_active(ac[2]),
		.low_voltage_level(lv[3]), .low_voltage_active(ac[3]), .charge_time_level(lv[4]),
		.charge_time_active(ac[4]), .serial_three_tx_level(lv[5]), .serial_three_tx_active(ac[5]),
		.serial_three_rx_level(lv[6]), .serial_three_rx_active(ac[6]), .serial_three_error_level(lv[7]),
		.serial_three_error_active(ac[7]), .serial_four_error_level(lv[8]), .serial_four_error_active(ac[8]),
		.usb_otg_level(lv[9]), .usb_otg_active(ac[9]), .i2c_three_master_level(lv[10]),
		.i2c_three_master_active(ac[10]), .i2c_three_slave_level(lv[11]), .i2c_three_slave_active(ac[11]),
		.spi_three_event_level(lv[12]), .spi_three_event_active(ac[12]), .spi_three_fault_level(lv[13]),
		.spi_three_fault_active(ac[13]), .serial_four_tx_level(lv[14]), .serial_four_tx_active(ac[14]),
		.serial_four_rx_level(lv[15]), .serial_four_rx_active(ac[15]));
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	function automatic logic [2:0] code_of(input int i);
		return 3'(mdl[IPR_SRC_REG[i]] >> IPR_SRC_LSB[i]);
	endfunction : code_of
	function automatic logic [15:0] exp_rd(input ipr_addr_t a);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 16; i++)
			m[i] = (code_of(i) == 3'h0);
		return (a < 3'h6) ? mdl[a] : (a == 3'h6) ? m : 16'h0000;
	endfunction : exp_rd
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic chk_lv();
		for (int i = 0; i < 16; i++)
		begin
			chk({13'h0000, lv[i]}, {13'h0000, code_of(i)});
			chk({15'h0000, ac[i]}, {15'h0000, code_of(i) != 3'h0});
		end
	endtask : chk_lv
	task automatic reset_model();
		for (int a = 0; a < 6; a++)
			mdl[a] = MSK[a] & 16'h4444;
	endtask : reset_model
	task automatic wr(input ipr_addr_t a, input logic [15:0] d);
		@(posedge clock);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clock);
		bus_wr <= 1'b0;
		if (a < 3'h6)
			mdl[a] = d & MSK[a];
		@(negedge clock);
		chk_lv();
	endtask : wr
	task automatic rd(input ipr_addr_t a);
		@(posedge clock);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clock);
		bus_rd <= 1'b0;
		@(negedge clock);
		chk(bus_rdata, exp_rd(a));
	endtask : rd
	task automatic print_verdict();
		$display("checked=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Cuts a hang short; the full run needs about 1500 cycles
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			err_count++;
			print_verdict();
		end
	end
	initial
	begin
		{rst, bus_wr, bus_rd, bus_addr, bus_wdata} = {1'b1, 21'h000000};
		reset_model();
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk_lv();
		for (int a = 0; a < 8; a++)
			rd(3'(a));
		// Every code into every field, spare bits set to prove they are dropped
		for (int c = 0; c < 8; c++)
		begin
			for (int a = 0; a < 8; a++)
				wr(3'(a), {4{1'b1, 3'(c)}});
			for (int a = 0; a < 8; a++)
				rd(3'(a));
		end
		repeat (300)
		begin
			wr(3'($random(seed)), 16'($random(seed)));
			rd(3'($random(seed)));
		end
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		reset_model();
		@(negedge clock);
		chk_lv();
		rd(IPR_ADDR_SPI3_SER4);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
